// ===== rtl/ssa_defines.vh
`ifndef SSA_DEFINES_VH
`define SSA_DEFINES_VH

// ----------------------------------------
// Slave mode selection codes
// ----------------------------------------
`define SSA_MODE_7BIT 4'h6
`define SSA_MODE_10BIT 4'h7
`define SSA_MODE_7BIT_SP 4'hE
`define SSA_MODE_10BIT_SP 4'hF
`define SSA_MODE_TEN_BIT_POS 0
`define SSA_MODE_SP_IRQ_POS 3

// ----------------------------------------
// Byte framing and address layout
// ----------------------------------------
`define SSA_BITS_PER_BYTE 4'h8
`define SSA_TEN_HI_PATTERN 5'h1E
`define SSA_RW_POS 0
`define SSA_TEN_HI_MSB 2
`define SSA_TEN_HI_LSB 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSA_OWN_ADDR_RST 8'h00
`define SSA_SHIFT_RST 8'h00

// ----------------------------------------
// Receive buffer shape
// ----------------------------------------
`define SSA_FIFO_WIDTH 8
`define SSA_FIFO_DEPTH 8
`define SSA_FIFO_AW 3

`endif

// ===== rtl/ssa_i2c_slave.v
`include "ssa_defines.vh"

// ----------------------------------------
// Receive FIFO with registered output
// ----------------------------------------
module ssa_fifo #(
  parameter WIDTH = `SSA_FIFO_WIDTH,
  parameter DEPTH = `SSA_FIFO_DEPTH,
  parameter AW = `SSA_FIFO_AW
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Fill side
  input wire wrValid,
  input wire [WIDTH-1:0] wrData,
  output wire wrReady,
  // Drain side
  output reg rdValid,
  output reg [WIDTH-1:0] rdData,
  input wire rdReady
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam [AW:0] FULL_COUNT = DEPTH;
  localparam [AW:0] ZERO_COUNT = 0;
  localparam [AW:0] LAST_COUNT = DEPTH - 1;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire push;
  wire load;

  // The output register counts as a slot, so DEPTH words in all
  assign wrReady = (count_r != FULL_COUNT) & ~((count_r == LAST_COUNT) & rdValid);
  assign push = wrValid & wrReady;
  assign load = (count_r != ZERO_COUNT) & (~rdValid | rdReady);

  always @(posedge clock)
  begin
    if (push)
      mem[wrPtr_r] <= wrData;
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      rdValid <= 1'b0;
      rdData <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (load)
      begin
        rdPtr_r <= rdPtr_r + 1'b1;
        rdData <= mem[rdPtr_r];
        rdValid <= 1'b1;
      end
      else if (rdReady)
        rdValid <= 1'b0;
      if (push & ~load)
        count_r <= count_r + 1'b1;
      else if (load & ~push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// ----------------------------------------
// Slave address and acknowledge engine
// ----------------------------------------
module ssa_i2c_slave (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Bus pins, open drain: enable low pulls the line low
  input wire sclIn,
  output reg sclOut,
  output reg sclOen,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOen,
  // Configuration
  input wire [3:0] slaveModeSelect,
  input wire startIrqEnable,
  input wire stopIrqEnable,
  input wire addressHoldEnable,
  input wire dataHoldEnable,
  input wire ackValueToSend,
  input wire bufferOverwriteEnable,
  input wire stretchEveryByte,
  // Software strobes
  input wire sclReleaseSet,
  input wire irqFlagClear,
  input wire overflowClear,
  input wire addrWrite,
  input wire [7:0] addrWriteData,
  input wire txWrite,
  input wire [7:0] txWriteData,
  // Received bytes
  output wire rxValid,
  output wire [7:0] rxData,
  input wire rxReady,
  // Status
  output reg [7:0] ownAddressReg,
  output reg serialPortIrqFlag,
  output reg startSeen,
  output reg stopSeen,
  output reg updateAddressNeeded,
  output reg ackPhaseFlag,
  output reg readDirection,
  output reg ackReceivedLevel,
  output reg bufferFull,
  output reg receiveOverflow,
  output reg sclRelease
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADRH = 7'h02;
  localparam [6:0] ST_ADRL = 7'h04;
  localparam [6:0] ST_RXD = 7'h08;
  localparam [6:0] ST_ACKO = 7'h10;
  localparam [6:0] ST_TXD = 7'h20;
  localparam [6:0] ST_ACKI = 7'h40;

  reg [1:0] sclSync_r;
  reg [1:0] sdaSync_r;
  reg sclPrev_r;
  reg sdaPrev_r;
  reg sawLow_r;
  reg [6:0] state_r;
  reg [6:0] afterAck_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg [7:0] txShift_r;
  reg autoAck_r;
  reg swAck_r;
  reg stretchAfter_r;
  reg uaAfter_r;
  reg priorMatch_r;
  reg pushReq_r;
  reg [7:0] pushData_r;
  wire fifoWrReady;
  wire sclS;
  wire sdaS;
  wire sclRise;
  wire sclFall;
  wire startDet;
  wire stopDet;
  wire modeOk;
  wire tenBit;
  wire irqOnStart;
  wire irqOnStop;
  wire anyHold;
  wire ovfCond;
  wire autoAck;
  wire hiMatch;
  wire sevenMatch;
  wire lowMatch;
  wire byteEnd;

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  assign sclS = sclSync_r[1];
  assign sdaS = sdaSync_r[1];
  assign sclRise = sclS & ~sclPrev_r;
  assign sclFall = ~sclS & sclPrev_r;
  assign startDet = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  assign stopDet = sclS & sclPrev_r & ~sdaPrev_r & sdaS & sawLow_r;

  assign modeOk = (slaveModeSelect == `SSA_MODE_7BIT) | (slaveModeSelect == `SSA_MODE_10BIT)
                | (slaveModeSelect == `SSA_MODE_7BIT_SP) | (slaveModeSelect == `SSA_MODE_10BIT_SP);
  assign tenBit = slaveModeSelect[`SSA_MODE_TEN_BIT_POS];
  assign irqOnStart = slaveModeSelect[`SSA_MODE_SP_IRQ_POS] | startIrqEnable;
  assign irqOnStop = slaveModeSelect[`SSA_MODE_SP_IRQ_POS] | stopIrqEnable;
  assign anyHold = addressHoldEnable | dataHoldEnable;

  assign ovfCond = ~fifoWrReady | receiveOverflow;
  assign autoAck = ~ovfCond | bufferOverwriteEnable;

  assign sevenMatch = shift_r[7:1] == ownAddressReg[7:1];
  assign hiMatch = (shift_r[7:3] == `SSA_TEN_HI_PATTERN)
                 & (shift_r[2:1] == ownAddressReg[`SSA_TEN_HI_MSB:`SSA_TEN_HI_LSB]);
  assign lowMatch = shift_r == ownAddressReg;
  assign byteEnd = sclFall & (bitCnt_r == `SSA_BITS_PER_BYTE);

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // Full buffer backs up into a not-ack unless bufferOverwriteEnable is set, so the master is throttled
  ssa_fifo #(
    .WIDTH(`SSA_FIFO_WIDTH),
    .DEPTH(`SSA_FIFO_DEPTH),
    .AW(`SSA_FIFO_AW)
  ) rxFifo (
    .clock(clock),
    .rstn(rstn),
    .wrValid(pushReq_r),
    .wrData(pushData_r),
    .wrReady(fifoWrReady),
    .rdValid(rxValid),
    .rdData(rxData),
    .rdReady(rxReady)
  );

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Software strobes are written before bus events so a same-cycle event wins
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOen <= 1'b1;
      sdaOen <= 1'b1;
      ownAddressReg <= `SSA_OWN_ADDR_RST;
      serialPortIrqFlag <= 1'b0;
      startSeen <= 1'b0;
      stopSeen <= 1'b0;
      updateAddressNeeded <= 1'b0;
      ackPhaseFlag <= 1'b0;
      readDirection <= 1'b0;
      ackReceivedLevel <= 1'b0;
      bufferFull <= 1'b0;
      receiveOverflow <= 1'b0;
      sclRelease <= 1'b1;
      sawLow_r <= 1'b0;
      state_r <= ST_IDLE;
      afterAck_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= `SSA_SHIFT_RST;
      txShift_r <= `SSA_SHIFT_RST;
      autoAck_r <= 1'b0;
      swAck_r <= 1'b0;
      stretchAfter_r <= 1'b0;
      uaAfter_r <= 1'b0;
      priorMatch_r <= 1'b0;
      pushReq_r <= 1'b0;
      pushData_r <= 8'h00;
    end
    else
    begin
      pushReq_r <= 1'b0;
      bufferFull <= ~fifoWrReady;
      if (sclFall)
        sawLow_r <= 1'b1;
      if (irqFlagClear)
        serialPortIrqFlag <= 1'b0;
      if (overflowClear)
        receiveOverflow <= 1'b0;
      if (sclReleaseSet)
        sclRelease <= 1'b1;
      if (addrWrite)
      begin
        ownAddressReg <= addrWriteData;
        updateAddressNeeded <= 1'b0;
        if (updateAddressNeeded)
          sclRelease <= 1'b1;
      end
      if (txWrite)
        txShift_r <= txWriteData;
      // Hold SCL only once it is already low
      if (sclRelease)
        sclOen <= 1'b1;
      else if (~sclS)
        sclOen <= 1'b0;

      if (!modeOk)
      begin
        state_r <= ST_IDLE;
        sdaOen <= 1'b1;
      end
      else if (startDet)
      begin
        state_r <= ST_ADRH;
        bitCnt_r <= 4'h0;
        sawLow_r <= 1'b0;
        ackPhaseFlag <= 1'b0;
        sdaOen <= 1'b1;
        startSeen <= 1'b1;
        stopSeen <= 1'b0;
        if (irqOnStart)
          serialPortIrqFlag <= 1'b1;
      end
      else if (stopDet)
      begin
        state_r <= ST_IDLE;
        priorMatch_r <= 1'b0;
        ackPhaseFlag <= 1'b0;
        sdaOen <= 1'b1;
        stopSeen <= 1'b1;
        startSeen <= 1'b0;
        if (irqOnStop)
          serialPortIrqFlag <= 1'b1;
      end
      else
      begin
        case (state_r)
          ST_ADRH, ST_ADRL, ST_RXD:
          begin
            if (sclRise && bitCnt_r != `SSA_BITS_PER_BYTE)
            begin
              shift_r <= {shift_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
            else if (byteEnd)
            begin
              autoAck_r <= autoAck;
              swAck_r <= anyHold;
              stretchAfter_r <= 1'b0;
              uaAfter_r <= 1'b0;
              afterAck_r <= ST_RXD;
              state_r <= ST_ACKO;
              if (~fifoWrReady)
                receiveOverflow <= 1'b1;
              pushReq_r <= fifoWrReady & autoAck;
              pushData_r <= shift_r;
              if (anyHold)
                ackPhaseFlag <= 1'b1;
              if ((state_r == ST_RXD) ? dataHoldEnable : addressHoldEnable)
              begin
                serialPortIrqFlag <= 1'b1;
                sclRelease <= 1'b0;
              end
              if (state_r == ST_RXD)
              begin
                stretchAfter_r <= stretchEveryByte;
              end
              else if (state_r == ST_ADRL)
              begin
                uaAfter_r <= 1'b1;
                priorMatch_r <= lowMatch;
                stretchAfter_r <= stretchEveryByte;
                if (!lowMatch)
                begin
                  afterAck_r <= ST_IDLE;
                  autoAck_r <= 1'b0;
                  swAck_r <= 1'b0;
                  pushReq_r <= 1'b0;
                  ackPhaseFlag <= 1'b0;
                end
              end
              else if (shift_r[`SSA_RW_POS])
              begin
                if (tenBit ? (hiMatch & priorMatch_r) : sevenMatch)
                begin
                  readDirection <= 1'b1;
                  stretchAfter_r <= 1'b1;
                  afterAck_r <= ST_TXD;
                end
                else
                begin
                  state_r <= ST_IDLE;
                  priorMatch_r <= 1'b0;
                  pushReq_r <= 1'b0;
                  ackPhaseFlag <= 1'b0;
                  receiveOverflow <= receiveOverflow & ~overflowClear;
                  serialPortIrqFlag <= serialPortIrqFlag & ~irqFlagClear;
                  sclRelease <= sclRelease | sclReleaseSet;
                end
              end
              else if (tenBit ? hiMatch : sevenMatch)
              begin
                readDirection <= 1'b0;
                if (tenBit)
                begin
                  priorMatch_r <= 1'b0;
                  uaAfter_r <= 1'b1;
                  afterAck_r <= ST_ADRL;
                end
                else
                  stretchAfter_r <= stretchEveryByte;
              end
              else
              begin
                state_r <= ST_IDLE;
                priorMatch_r <= 1'b0;
                pushReq_r <= 1'b0;
                ackPhaseFlag <= 1'b0;
                receiveOverflow <= receiveOverflow & ~overflowClear;
                serialPortIrqFlag <= serialPortIrqFlag & ~irqFlagClear;
                sclRelease <= sclRelease | sclReleaseSet;
              end
            end
          end
          ST_ACKO:
          begin
            // drive ack only while SCL low
            if (~sclS && !sclRise)
              sdaOen <= ~(autoAck_r & ~(swAck_r & ackValueToSend));
            if (sclFall)
            begin
              bitCnt_r <= 4'h0;
              sdaOen <= 1'b1;
              ackPhaseFlag <= 1'b0;
              state_r <= sdaOen ? ST_IDLE : afterAck_r;
              if (uaAfter_r)
              begin
                updateAddressNeeded <= 1'b1;
                serialPortIrqFlag <= 1'b1;
                sclRelease <= 1'b0;
              end
              if (!sdaOen)
              begin
                serialPortIrqFlag <= 1'b1;
                if (stretchAfter_r)
                  sclRelease <= 1'b0;
              end
            end
          end
          ST_TXD:
          begin
            if (sclFall)
            begin
              txShift_r <= {txShift_r[6:0], 1'b0};
              bitCnt_r <= bitCnt_r + 4'h1;
              if (bitCnt_r == `SSA_BITS_PER_BYTE - 4'h1)
              begin
                state_r <= ST_ACKI;
                sdaOen <= 1'b1;
              end
            end
            else if (~sclS)
              sdaOen <= txShift_r[7];
          end
          ST_ACKI:
          begin
            // latch master ack at ninth rise
            if (sclRise)
              ackReceivedLevel <= sdaS;
            if (sclFall)
            begin
              bitCnt_r <= 4'h0;
              serialPortIrqFlag <= 1'b1;
              if (ackReceivedLevel)
                state_r <= ST_IDLE;
              else
              begin
                state_r <= ST_TXD;
                sclRelease <= 1'b0;
              end
            end
          end
          default:
          begin
            sdaOen <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== testbench/ssa_i2c_slave_props.sv
module ssa_i2c_slave_props (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Bus pins
  input wire sclIn,
  input wire sclOen,
  input wire sdaIn,
  // Configuration and strobes
  input wire [3:0] slaveModeSelect,
  input wire addressHoldEnable,
  input wire dataHoldEnable,
  input wire sclReleaseSet,
  input wire irqFlagClear,
  input wire overflowClear,
  input wire addrWrite,
  // Status
  input wire serialPortIrqFlag,
  input wire startSeen,
  input wire stopSeen,
  input wire updateAddressNeeded,
  input wire ackPhaseFlag,
  input wire receiveOverflow,
  input wire sclRelease
);
  timeunit 1ns;
  timeprecision 100ps;

  wire slaveOn;

  // All four slave mode codes share these two bits
  assign slaveOn = slaveModeSelect[2:1] == 2'b11;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence seqSclPulled;
    ##[1:2] !sclOen;
  endsequence

  chk_start_seen: assert property (
    $fell(sdaIn) && sclIn && $past(sclIn) && slaveOn |-> ##[2:4] startSeen)
    else $error("start not flagged");
  chk_stop_seen: assert property (
    $rose(sdaIn) && sclIn && $past(sclIn) && slaveOn |-> ##[2:4] stopSeen)
    else $error("stop not flagged");
  chk_seen_exclusive: assert property (!(startSeen && stopSeen))
    else $error("start and stop both flagged");
  chk_irq_sticky: assert property (
    serialPortIrqFlag && !irqFlagClear |=> serialPortIrqFlag)
    else $error("irq flag dropped");
  chk_ovf_sticky: assert property (
    receiveOverflow && !overflowClear |=> receiveOverflow)
    else $error("overflow dropped");
  chk_ua_clear: assert property (addrWrite |=> !updateAddressNeeded)
    else $error("address write kept update flag");
  chk_ua_holds: assert property (
    updateAddressNeeded && $past(updateAddressNeeded, 4) |-> !sclOen)
    else $error("SCL free while address update pending");
  chk_ack_phase: assert property (
    ackPhaseFlag |-> addressHoldEnable || dataHoldEnable)
    else $error("ack phase flag without hold");
  chk_stretch_pull: assert property ($fell(sclRelease) |-> seqSclPulled)
    else $error("SCL not held after release cleared");
  chk_release_frees: assert property (
    sclReleaseSet && !updateAddressNeeded |-> ##[1:2] sclOen)
    else $error("SCL not freed by release");
endmodule

bind ssa_i2c_slave ssa_i2c_slave_props chk_u (
  .clock(clock), .rstn(rstn), .sclIn(sclIn), .sclOen(sclOen), .sdaIn(sdaIn),
  .slaveModeSelect(slaveModeSelect), .addressHoldEnable(addressHoldEnable),
  .dataHoldEnable(dataHoldEnable), .sclReleaseSet(sclReleaseSet),
  .irqFlagClear(irqFlagClear), .overflowClear(overflowClear), .addrWrite(addrWrite),
  .serialPortIrqFlag(serialPortIrqFlag), .startSeen(startSeen), .stopSeen(stopSeen),
  .updateAddressNeeded(updateAddressNeeded), .ackPhaseFlag(ackPhaseFlag),
  .receiveOverflow(receiveOverflow), .sclRelease(sclRelease)
);

// ===== testbench/ssa_i2c_master_model.sv
module ssa_i2c_master_model (
  // Timing reference
  input wire logic clock,
  // Wired-and bus levels
  input wire logic sclWire,
  input wire logic sdaWire,
  // Open-drain drives, 1 releases the line to its pull-up
  output logic sclDrv,
  output logic sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic quarter();
    repeat (2) @(negedge clock);
  endtask

  task automatic scl_high();
    int i;
    sclDrv = 1'b1;
    for (i = 0; i < 3000 && sclWire !== 1'b1; i++)
      @(negedge clock);
    quarter();
  endtask

  task automatic clk_bit(input logic b, output logic s);
    quarter();
    sdaDrv = b;
    quarter();
    scl_high();
    s = sdaWire;
    quarter();
    sclDrv = 1'b0;
  endtask

  task automatic start_cond();
    quarter();
    sdaDrv = 1'b1;
    quarter();
    scl_high();
    sdaDrv = 1'b0;
    quarter();
    quarter();
    sclDrv = 1'b0;
  endtask

  task automatic stop_cond();
    quarter();
    sdaDrv = 1'b0;
    quarter();
    scl_high();
    sdaDrv = 1'b1;
    quarter();
    quarter();
  endtask

  task automatic write_byte(input logic [7:0] d, output logic nack);
    int i;
    logic s;
    for (i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, nack);
  endtask

  task automatic read_byte(input logic mnack, output logic [7:0] d);
    int i;
    logic s;
    for (i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(mnack, s);
  endtask
endmodule

// ===== testbench/tb_ssa_i2c_slave.sv
module tb_ssa_i2c_slave;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, rstn, rxReady, ackValueToSend, bufferOverwriteEnable, stretchEveryByte;
  logic startIrqEnable, stopIrqEnable, addressHoldEnable, dataHoldEnable;
  logic sclReleaseSet, irqFlagClear, overflowClear, addrWrite, txWrite;
  logic [3:0] slaveModeSelect;
  logic [7:0] addrWriteData, txWriteData;
  wire logic sclOut, sclOen, sdaOut, sdaOen, rxValid, serialPortIrqFlag, startSeen;
  wire logic stopSeen, updateAddressNeeded, ackPhaseFlag, readDirection, ackReceivedLevel;
  wire logic bufferFull, receiveOverflow, sclRelease, mstScl, mstSda, sclWire, sdaWire;
  wire logic [7:0] rxData, ownAddressReg;
  int errors = 0;
  int testsRun = 0;
  int cycles = 0;

  // Open-drain: any party pulling wins
  assign sclWire = mstScl & (sclOen ? 1'b1 : sclOut);
  assign sdaWire = mstSda & (sdaOen ? 1'b1 : sdaOut);

  ssa_i2c_slave dut_u (
    .clock(clock), .rstn(rstn), .sclIn(sclWire), .sclOut(sclOut), .sclOen(sclOen),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOen(sdaOen), .slaveModeSelect(slaveModeSelect),
    .startIrqEnable(startIrqEnable), .stopIrqEnable(stopIrqEnable),
    .addressHoldEnable(addressHoldEnable), .dataHoldEnable(dataHoldEnable),
    .ackValueToSend(ackValueToSend), .bufferOverwriteEnable(bufferOverwriteEnable),
    .stretchEveryByte(stretchEveryByte), .sclReleaseSet(sclReleaseSet),
    .irqFlagClear(irqFlagClear), .overflowClear(overflowClear), .addrWrite(addrWrite),
    .addrWriteData(addrWriteData), .txWrite(txWrite), .txWriteData(txWriteData),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .ownAddressReg(ownAddressReg),
    .serialPortIrqFlag(serialPortIrqFlag), .startSeen(startSeen), .stopSeen(stopSeen),
    .updateAddressNeeded(updateAddressNeeded), .ackPhaseFlag(ackPhaseFlag),
    .readDirection(readDirection), .ackReceivedLevel(ackReceivedLevel),
    .bufferFull(bufferFull), .receiveOverflow(receiveOverflow), .sclRelease(sclRelease)
  );

  ssa_i2c_master_model mst_u (
    .clock(clock), .sclWire(sclWire), .sdaWire(sdaWire), .sclDrv(mstScl), .sdaDrv(mstSda)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic close_out();
    if (errors == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One software strobe, held for a single clock
  task automatic sw(input int k, input logic [7:0] d);
    @(negedge clock);
    case (k)
      0: sclReleaseSet = 1'b1;
      1: irqFlagClear = 1'b1;
      2: overflowClear = 1'b1;
      3: addrWrite = 1'b1;
      default: txWrite = 1'b1;
    endcase
    addrWriteData = d;
    txWriteData = d;
    @(negedge clock);
    {sclReleaseSet, irqFlagClear, overflowClear, addrWrite, txWrite} = '0;
  endtask

  task automatic wait_stretch();
    int i;
    for (i = 0; i < 3000 && sclOen !== 1'b0; i++)
      @(negedge clock);
    repeat (2) @(negedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes();
    logic [3:0] modes [4] = '{4'h6, 4'h7, 4'hE, 4'hF};
    logic nack, en;
    int i;
    for (i = 0; i < 8; i++)
    begin
      en = i >= 4;
      slaveModeSelect = modes[i % 4];
      startIrqEnable = en;
      stopIrqEnable = en;
      sw(1, 8'h00);
      mst_u.start_cond();
      repeat (4) @(negedge clock);
      chk(startSeen, 1'b1);
      chk(serialPortIrqFlag, modes[i % 4][3] | en);
      sw(1, 8'h00);
      mst_u.write_byte(8'h02, nack);
      repeat (4) @(negedge clock);
      chk(nack, 1'b1);
      chk(serialPortIrqFlag, 1'b0);
      mst_u.stop_cond();
      chk(stopSeen, 1'b1);
      chk(serialPortIrqFlag, modes[i % 4][3] | en);
    end
    startIrqEnable = 1'b0;
    stopIrqEnable = 1'b0;
    slaveModeSelect = 4'h0;
    mst_u.start_cond();
    repeat (4) @(negedge clock);
    chk(startSeen, 1'b0);
    mst_u.stop_cond();
  endtask

  task automatic t_fill();
    logic nack;
    int k;
    slaveModeSelect = 4'h6;
    rxReady = 1'b0;
    sw(1, 8'h00);
    mst_u.start_cond();
    mst_u.write_byte(8'hA0, nack);
    repeat (4) @(negedge clock);
    chk(nack, 1'b0);
    chk(readDirection, 1'b0);
    chk(serialPortIrqFlag, 1'b1);
    for (k = 1; k < 8; k++)
    begin
      mst_u.write_byte(8'(8'h0F + k), nack);
      chk(nack, 1'b0);
    end
    mst_u.write_byte(8'h17, nack);
    repeat (4) @(negedge clock);
    chk(nack, 1'b1);
    chk(receiveOverflow, 1'b1);
    chk(bufferFull, 1'b1);
    mst_u.stop_cond();
    for (k = 0; k < 8; k++)
    begin
      chk(rxValid, 1'b1);
      chk(rxData, k == 0 ? 8'hA0 : 8'(8'h0F + k));
      rxReady = 1'b1;
      @(negedge clock);
      rxReady = 1'b0;
      @(negedge clock);
    end
    chk(rxValid, 1'b0);
    sw(2, 8'h00);
    chk(receiveOverflow, 1'b0);
    rxReady = 1'b1;
  endtask

  task automatic t_read();
    logic nack;
    logic [7:0] d;
    mst_u.start_cond();
    mst_u.write_byte(8'hA1, nack);
    chk(nack, 1'b0);
    fork
      mst_u.read_byte(1'b1, d);
      begin
        wait_stretch();
        chk(readDirection, 1'b1);
        chk(sclRelease, 1'b0);
        sw(4, 8'h96);
        sw(0, 8'h00);
      end
    join
    chk(d, 8'h96);
    repeat (4) @(negedge clock);
    chk(ackReceivedLevel, 1'b1);
    mst_u.stop_cond();
  endtask

  task automatic t_hold();
    logic nack;
    addressHoldEnable = 1'b1;
    ackValueToSend = 1'b1;
    sw(1, 8'h00);
    mst_u.start_cond();
    fork
      mst_u.write_byte(8'hA0, nack);
      begin
        wait_stretch();
        chk(ackPhaseFlag, 1'b1);
        chk(serialPortIrqFlag, 1'b1);
        sw(1, 8'h00);
        sw(0, 8'h00);
      end
    join
    chk(nack, 1'b1);
    repeat (4) @(negedge clock);
    chk(serialPortIrqFlag, 1'b0);
    chk(ackPhaseFlag, 1'b0);
    mst_u.stop_cond();
    addressHoldEnable = 1'b0;
    ackValueToSend = 1'b0;
  endtask

  task automatic t_ten_bit();
    logic nack;
    logic [7:0] d;
    slaveModeSelect = 4'h7;
    sw(3, 8'h06);
    mst_u.start_cond();
    mst_u.write_byte(8'hF6, nack);
    chk(nack, 1'b0);
    fork
      mst_u.write_byte(8'h5A, nack);
      begin
        wait_stretch();
        chk(updateAddressNeeded, 1'b1);
        sw(1, 8'h00);
        sw(3, 8'h5A);
        chk(updateAddressNeeded, 1'b0);
      end
    join
    chk(nack, 1'b0);
    fork
      begin
        mst_u.start_cond();
        mst_u.write_byte(8'hF7, nack);
      end
      begin
        wait_stretch();
        chk(updateAddressNeeded, 1'b1);
        chk(serialPortIrqFlag, 1'b1);
        sw(3, 8'h06);
      end
    join
    chk(nack, 1'b0);
    fork
      mst_u.read_byte(1'b1, d);
      begin
        wait_stretch();
        chk(readDirection, 1'b1);
        sw(4, 8'h3C);
        sw(0, 8'h00);
      end
    join
    chk(d, 8'h3C);
    mst_u.stop_cond();
  endtask

  // Hang guard: the whole sequence needs well under 10000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("ERROR %0t: run too long", $time);
      close_out();
    end
  end

  initial
  begin
    rstn = 1'b0;
    slaveModeSelect = 4'h6;
    {startIrqEnable, stopIrqEnable, addressHoldEnable, dataHoldEnable} = '0;
    {ackValueToSend, bufferOverwriteEnable, stretchEveryByte} = '0;
    {sclReleaseSet, irqFlagClear, overflowClear, addrWrite, txWrite} = '0;
    addrWriteData = 8'h00;
    txWriteData = 8'h00;
    rxReady = 1'b1;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    sw(3, 8'hA0);
    chk(ownAddressReg, 8'hA0);
    t_modes();
    t_fill();
    t_read();
    t_hold();
    t_ten_bit();
    close_out();
  end
endmodule
